// ---- design/rbt_transceiver.sv ----
// registered inverting bus transceiver with an AXI4-Lite control port
module rbt_transceiver
    import rbt_pkg::*;
#(
    parameter int WIDTH = RBT_WIDTH_DEF
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [WIDTH-1:0] A_IN,
    output logic [WIDTH-1:0] A_OUT,
    output logic A_OE_N,
    input wire logic [WIDTH-1:0] B_IN,
    output logic [WIDTH-1:0] B_OUT,
    output logic B_OE_N,
    input wire logic A_CAPTURE_CLOCK,
    input wire logic B_CAPTURE_CLOCK,
    input wire logic [RBT_ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [RBT_DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [RBT_ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [RBT_DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // ----------------------------------------------------------------
    // parameter check
    // ----------------------------------------------------------------
    if (WIDTH < 1 || WIDTH > RBT_HALF - 1) begin : g_width_chk
        $error("WIDTH must lie between 1 and 15");
    end

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic rbt_hit(input logic [RBT_ADDR_W-1:0] addr,
                                     input logic [11:0] off);
        rbt_hit = (addr[RBT_ADDR_W-1:2] == off[RBT_ADDR_W-1:2]);
    endfunction

    function automatic logic rbt_known(input logic [RBT_ADDR_W-1:0] addr);
        rbt_known = rbt_hit(addr, RBT_OFF_CTRL)
            || rbt_hit(addr, RBT_OFF_STORE)
            || rbt_hit(addr, RBT_OFF_LIVE);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [RBT_CTRL_W-1:0] ctrl_reg;
    logic [WIDTH-1:0] a_store_reg;
    logic [WIDTH-1:0] b_store_reg;
    logic a_cap_prev_reg;
    logic b_cap_prev_reg;
    logic [WIDTH-1:0] a_out_reg;
    logic [WIDTH-1:0] b_out_reg;
    logic a_oe_n_reg;
    logic b_oe_n_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [RBT_DATA_W-1:0] rdata_reg;
    logic [RBT_ADDR_W-1:0] aw_addr_reg;
    logic [RBT_DATA_W-1:0] w_data_reg;
    logic [3:0] w_strb_reg;

    // ----------------------------------------------------------------
    // control fields and transfer paths
    // ----------------------------------------------------------------
    wire b_side_drive_enable = ctrl_reg[RBT_BIT_B_DRV];
    wire a_side_drive_enable_n = ctrl_reg[RBT_BIT_A_DRV_N];
    wire b_source_select = ctrl_reg[RBT_BIT_B_SRC];
    wire a_source_select = ctrl_reg[RBT_BIT_A_SRC];
    wire a_cap_rise = A_CAPTURE_CLOCK && !a_cap_prev_reg;
    wire b_cap_rise = B_CAPTURE_CLOCK && !b_cap_prev_reg;
    // mux between live and stored source, then invert
    wire [WIDTH-1:0] b_out_next = b_source_select ? ~a_store_reg : ~A_IN;
    wire [WIDTH-1:0] a_out_next = a_source_select ? ~b_store_reg : ~B_IN;
    // drive only when enabled, otherwise the port is an input
    wire b_oe_n_next = !b_side_drive_enable;
    wire a_oe_n_next = a_side_drive_enable_n;

    // ----------------------------------------------------------------
    // bus outputs
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            a_out_reg <= '0;
            b_out_reg <= '0;
            a_oe_n_reg <= 1'b1;
            b_oe_n_reg <= 1'b1;
            a_cap_prev_reg <= 1'b1;
            b_cap_prev_reg <= 1'b1;
        end else if (CE) begin
            a_out_reg <= a_out_next;
            b_out_reg <= b_out_next;
            a_oe_n_reg <= a_oe_n_next;
            b_oe_n_reg <= b_oe_n_next;
            a_cap_prev_reg <= A_CAPTURE_CLOCK;
            b_cap_prev_reg <= B_CAPTURE_CLOCK;
        end
    end

    // ----------------------------------------------------------------
    // capture registers, one pair per bit channel, no reset
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (CE && a_cap_rise) begin
            a_store_reg <= A_IN;
        end
        if (CE && b_cap_rise) begin
            b_store_reg <= B_IN;
        end
    end

    // ----------------------------------------------------------------
    // register bus decode
    // ----------------------------------------------------------------
    wire aw_take = S_AXI_AWVALID && awready_reg;
    wire w_take = S_AXI_WVALID && wready_reg;
    wire wr_go = !awready_reg && !wready_reg && !bvalid_reg;
    wire wr_ctrl = wr_go && rbt_hit(aw_addr_reg, RBT_OFF_CTRL)
        && w_strb_reg[0];
    wire [1:0] wr_resp = rbt_known(aw_addr_reg) ? RBT_RESP_OKAY
        : RBT_RESP_SLVERR;
    wire ar_take = S_AXI_ARVALID && arready_reg;
    wire [RBT_DATA_W-1:0] rd_ctrl = {{(RBT_DATA_W-RBT_CTRL_W){1'b0}},
        ctrl_reg};
    wire [RBT_DATA_W-1:0] rd_store = {{(RBT_HALF-WIDTH){1'b0}},
        b_store_reg, {(RBT_HALF-WIDTH){1'b0}}, a_store_reg};
    wire [RBT_DATA_W-1:0] rd_live = {{(RBT_HALF-WIDTH){1'b0}}, B_IN,
        {(RBT_HALF-WIDTH){1'b0}}, A_IN};
    wire [RBT_DATA_W-1:0] rd_data =
        rbt_hit(S_AXI_ARADDR, RBT_OFF_CTRL) ? rd_ctrl :
        rbt_hit(S_AXI_ARADDR, RBT_OFF_STORE) ? rd_store :
        rbt_hit(S_AXI_ARADDR, RBT_OFF_LIVE) ? rd_live : '0;
    wire [1:0] rd_resp = rbt_known(S_AXI_ARADDR) ? RBT_RESP_OKAY
        : RBT_RESP_SLVERR;

    // ----------------------------------------------------------------
    // write channel
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= RBT_RESP_OKAY;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            ctrl_reg <= RBT_CTRL_RST;
        end else if (CE) begin
            if (aw_take) begin
                aw_addr_reg <= S_AXI_AWADDR;
                awready_reg <= 1'b0;
            end
            if (w_take) begin
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
                wready_reg <= 1'b0;
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_resp;
            end
            if (wr_ctrl) begin
                ctrl_reg <= w_data_reg[RBT_CTRL_W-1:0];
            end
            if (bvalid_reg && S_AXI_BREADY) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= RBT_RESP_OKAY;
            rdata_reg <= '0;
        end else if (CE) begin
            if (ar_take) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rresp_reg <= rd_resp;
                rdata_reg <= rd_data;
            end
            if (rvalid_reg && S_AXI_RREADY) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // output wiring
    // ----------------------------------------------------------------
    assign A_OUT = a_out_reg;
    assign B_OUT = b_out_reg;
    assign A_OE_N = a_oe_n_reg;
    assign B_OE_N = b_oe_n_reg;
    assign S_AXI_AWREADY = awready_reg;
    assign S_AXI_WREADY = wready_reg;
    assign S_AXI_BVALID = bvalid_reg;
    assign S_AXI_BRESP = bresp_reg;
    assign S_AXI_ARREADY = arready_reg;
    assign S_AXI_RVALID = rvalid_reg;
    assign S_AXI_RRESP = rresp_reg;
    assign S_AXI_RDATA = rdata_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    live_b_path_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && b_side_drive_enable && !b_source_select
        |=> !B_OE_N && B_OUT == ~$past(A_IN))
        else $error("B port not driven from inverted live A");

    live_a_path_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && !a_side_drive_enable_n && !a_source_select
        |=> !A_OE_N && A_OUT == ~$past(B_IN))
        else $error("A port not driven from inverted live B");

    stored_both_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && b_side_drive_enable && !a_side_drive_enable_n
        && b_source_select && a_source_select
        |=> !A_OE_N && !B_OE_N && B_OUT == ~$past(a_store_reg)
        && A_OUT == ~$past(b_store_reg))
        else $error("stored data not driven onto both ports");

    stored_select_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && b_source_select
        ##1 CE && b_source_select && $stable(a_store_reg)
        |=> $stable(B_OUT))
        else $error("stored B output moved without a capture");

    isolation_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && !b_side_drive_enable && a_side_drive_enable_n
        |=> A_OE_N && B_OE_N)
        else $error("a port drives while isolated");

    capture_a_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && A_CAPTURE_CLOCK && !a_cap_prev_reg
        |=> a_store_reg == $past(A_IN))
        else $error("A capture register missed its edge");

    capture_b_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && B_CAPTURE_CLOCK && !b_cap_prev_reg
        |=> b_store_reg == $past(B_IN))
        else $error("B capture register missed its edge");

    hold_store_a:
    assert property (@(posedge CLK) disable iff (RST)
        !(CE && a_cap_rise) && !(CE && b_cap_rise)
        |=> $stable(a_store_reg) && $stable(b_store_reg))
        else $error("capture register changed without an edge");

    dual_load_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && !B_OE_N && a_cap_rise && b_cap_rise
        |=> a_store_reg == $past(A_IN) && b_store_reg == $past(B_IN))
        else $error("simultaneous capture lost a register");

    reinforce_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && b_side_drive_enable && !a_side_drive_enable_n
        && !b_source_select && !a_source_select
        |=> !A_OE_N && !B_OE_N && A_OUT == ~$past(B_IN)
        && B_OUT == ~$past(A_IN))
        else $error("ports do not reinforce each other");

    dual_load_b_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && !A_OE_N && a_cap_rise && b_cap_rise
        |=> a_store_reg == $past(A_IN) && b_store_reg == $past(B_IN))
        else $error("simultaneous capture from B lost a register");

    stored_a_sel_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && a_source_select
        ##1 CE && a_source_select && $stable(b_store_reg)
        |=> $stable(A_OUT))
        else $error("stored A output moved without a capture");

    ce_freeze_a:
    assert property (@(posedge CLK) disable iff (RST)
        !CE |=> $stable(A_OUT) && $stable(B_OUT)
        && $stable(A_OE_N) && $stable(B_OE_N))
        else $error("outputs moved while the clock enable was low");

    read_answer_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && S_AXI_ARVALID && S_AXI_ARREADY
        |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read request not answered next cycle");

    write_done_a:
    assert property (@(posedge CLK) disable iff (RST)
        CE && S_AXI_BVALID && S_AXI_BREADY
        |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
        else $error("write channel not reopened after response");
endmodule

// ---- design/rbt_pkg.sv ----
// constants shared by the registered bus transceiver
package rbt_pkg;
    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    localparam int RBT_ADDR_W = 12;
    localparam int RBT_DATA_W = 32;
    localparam logic [11:0] RBT_OFF_CTRL = 12'h000;
    localparam logic [11:0] RBT_OFF_STORE = 12'h004;
    localparam logic [11:0] RBT_OFF_LIVE = 12'h008;
    localparam logic [1:0] RBT_RESP_OKAY = 2'h0;
    localparam logic [1:0] RBT_RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int RBT_CTRL_W = 4;
    localparam int RBT_BIT_B_DRV = 0;
    localparam int RBT_BIT_A_DRV_N = 1;
    localparam int RBT_BIT_B_SRC = 2;
    localparam int RBT_BIT_A_SRC = 3;
    localparam logic [3:0] RBT_CTRL_RST = 4'h2;
    // ----------------------------------------------------------------
    // data layout
    // ----------------------------------------------------------------
    localparam int RBT_HALF = 16;
    localparam int RBT_WIDTH_DEF = 8;
endpackage

// ---- tb/rbt_bus_model.sv ----
// wire model of the A and B buses around the transceiver
module rbt_bus_model #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] a_out,
    input wire logic a_oe_n,
    input wire logic [WIDTH-1:0] b_out,
    input wire logic b_oe_n,
    input wire logic [WIDTH-1:0] a_ext,
    input wire logic a_ext_en,
    input wire logic [WIDTH-1:0] b_ext,
    input wire logic b_ext_en,
    output logic [WIDTH-1:0] a_bus,
    output logic [WIDTH-1:0] b_bus
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [WIDTH-1:0] a_flt = '0;
    logic [WIDTH-1:0] b_flt = '0;
    // an undriven line flips every cycle
    always @(posedge clk) begin
        a_flt <= ~a_bus;
        b_flt <= ~b_bus;
    end
    // two drivers that disagree give x
    function automatic logic [WIDTH-1:0] res(input logic dn,
        input logic [WIDTH-1:0] dv, input logic en,
        input logic [WIDTH-1:0] ev, input logic [WIDTH-1:0] fl);
        if (dn === 1'b0 && en)
            return (dv === ev) ? dv : 'x;
        if (dn === 1'b0)
            return dv;
        return en ? ev : fl;
    endfunction
    assign a_bus = res(a_oe_n, a_out, a_ext_en, a_ext, a_flt);
    assign b_bus = res(b_oe_n, b_out, b_ext_en, b_ext, b_flt);
endmodule

// ---- tb/tb_registered_bus_transceiver.sv ----
// self-checking bench for the registered bus transceiver
module tb_registered_bus_transceiver
    import rbt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
    logic [7:0] a_out, b_out, a_bus, b_bus, a_ext = '0, b_ext = '0;
    logic a_oe_n, b_oe_n, awready, wready, bvalid, arready, rvalid;
    logic a_en = 1'b0, b_en = 1'b0, a_cap = 1'b0, b_cap = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp, r;
    int fail_count = 0, checks = 0, cyc = 0;
    rbt_transceiver i_dut (.CLK(clk), .RST(rst), .CE(ce),
        .A_IN(a_bus), .A_OUT(a_out), .A_OE_N(a_oe_n),
        .B_IN(b_bus), .B_OUT(b_out), .B_OE_N(b_oe_n),
        .A_CAPTURE_CLOCK(a_cap), .B_CAPTURE_CLOCK(b_cap),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    rbt_bus_model i_bus (.clk(clk), .a_out(a_out), .a_oe_n(a_oe_n),
        .b_out(b_out), .b_oe_n(b_oe_n), .a_ext(a_ext), .a_ext_en(a_en),
        .b_ext(b_ext), .b_ext_en(b_en), .a_bus(a_bus), .b_bus(b_bus));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] rs);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end while ((awvalid && awready !== 1'b1) ||
                   (wvalid && wready !== 1'b1));
        do @(posedge clk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp,
                        input logic [1:0] er, input string what);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        chk(what, rdata, exp);
        chk("rresp", rresp, er);
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ctrl(input logic [3:0] v);
        wr(RBT_OFF_CTRL, {28'h000_0000, v}, 4'hf, r);
        chk("bresp", r, RBT_RESP_OKAY);
    endtask
    task automatic cap(input logic a, input logic b);
        a_cap <= a;
        b_cap <= b;
        repeat (2) @(posedge clk);
        a_cap <= 1'b0;
        b_cap <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_isolate();
        chk("a_oe_n", a_oe_n, 1'b1);
        chk("b_oe_n", b_oe_n, 1'b1);
        rchk(RBT_OFF_CTRL, 32'h0000_0002, RBT_RESP_OKAY, "ctrl");
        a_ext <= 8'h12;
        b_ext <= 8'h34;
        a_en <= 1'b1;
        b_en <= 1'b1;
        repeat (2) @(posedge clk);
        cap(1'b1, 1'b1);
        rchk(RBT_OFF_STORE, 32'h0034_0012, RBT_RESP_OKAY, "st");
        a_ext <= 8'h56;
        repeat (2) @(posedge clk);
        cap(1'b1, 1'b0);
        rchk(RBT_OFF_STORE, 32'h0034_0056, RBT_RESP_OKAY, "st");
        chk("a_oe_n", a_oe_n, 1'b1);
    endtask
    task automatic t_stored();
        a_en <= 1'b0;
        b_en <= 1'b0;
        ctrl(4'hd);
        repeat (3) @(posedge clk);
        chk("a_bus", a_bus, 8'hcb);
        chk("b_bus", b_bus, 8'ha9);
        cap(1'b1, 1'b0); // stagger the two edges
        cap(1'b0, 1'b1);
        rchk(RBT_OFF_STORE, 32'h0034_00cb, RBT_RESP_OKAY, "st");
    endtask
    task automatic t_live_ab();
        logic [7:0] v [3] = '{8'h5a, 8'h00, 8'hff};
        ctrl(4'h2);
        a_en <= 1'b1;
        ctrl(4'h3);
        foreach (v[i]) begin
            a_ext <= v[i];
            repeat (3) @(posedge clk); // bus steady before joint edge
            chk("b_bus", b_bus, {~v[i]});
            chk("oe", {a_oe_n, b_oe_n}, 2'b10);
            cap(1'b1, 1'b1);
            rchk(RBT_OFF_STORE, {8'h00, ~v[i], 8'h00, v[i]},
                 RBT_RESP_OKAY, "st");
        end
    endtask
    task automatic t_live_ba();
        ctrl(4'h2);
        a_en <= 1'b0;
        b_en <= 1'b1;
        b_ext <= 8'h21;
        ctrl(4'h0);
        repeat (3) @(posedge clk);
        chk("a_bus", a_bus, 8'hde);
        chk("oe", {a_oe_n, b_oe_n}, 2'b01);
        cap(1'b1, 1'b1);
        rchk(RBT_OFF_STORE, 32'h0021_00de, RBT_RESP_OKAY, "st");
    endtask
    task automatic t_hold();
        ctrl(4'h2);
        b_en <= 1'b0;
        a_en <= 1'b1;
        a_ext <= 8'h3c;
        ctrl(4'h3);
        repeat (3) @(posedge clk);
        ctrl(4'h1);
        a_en <= 1'b0;
        repeat (6) @(posedge clk);
        chk("a_bus", a_bus, 8'h3c);
        rchk(RBT_OFF_LIVE, 32'h00c3_003c, RBT_RESP_OKAY, "live");
    endtask
    task automatic t_axi();
        rchk(12'h00c, 32'h0000_0000, RBT_RESP_SLVERR, "unmapped");
        wr(12'h010, 32'h0000_000f, 4'hf, r);
        chk("bresp", r, RBT_RESP_SLVERR);
        wr(RBT_OFF_STORE, 32'h0000_00ff, 4'hf, r);
        chk("bresp", r, RBT_RESP_OKAY);
        wr(RBT_OFF_CTRL, 32'h0000_000e, 4'he, r);
        chk("bresp", r, RBT_RESP_OKAY);
        rchk(RBT_OFF_CTRL, 32'h0000_0001, RBT_RESP_OKAY, "ctrl");
    endtask
    task automatic t_ce_rst();
        ce <= 1'b0;
        a_cap <= 1'b1;
        b_cap <= 1'b1;
        repeat (3) @(posedge clk);
        chk("a_bus", a_bus, 8'h3c);
        chk("b_bus", b_bus, 8'hc3);
        a_cap <= 1'b0;
        b_cap <= 1'b0;
        ce <= 1'b1;
        @(posedge clk);
        rchk(RBT_OFF_STORE, 32'h0021_00de, RBT_RESP_OKAY, "st");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("oe", {a_oe_n, b_oe_n}, 2'b11);
        rchk(RBT_OFF_CTRL, 32'h0000_0002, RBT_RESP_OKAY, "ctrl");
        rchk(RBT_OFF_STORE, 32'h0021_00de, RBT_RESP_OKAY, "st");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_isolate();
        t_stored();
        t_live_ab();
        t_live_ba();
        t_hold();
        t_axi();
        t_ce_rst();
        print_verdict();
    end
endmodule
